// file: verilog/sllp_defs.vh
// sllp_defs.vh: constants of the sector lock protection block
`ifndef SLLP_DEFS_VH
`define SLLP_DEFS_VH

// ****************************************
// array geometry
// ****************************************
`define SLLP_SECTORS       1024
`define SLLP_SUBS          16
`define SLLP_TL_ENTRIES    1056
`define SLLP_TL_FIRST_SUB  11'h400
`define SLLP_TL_LAST_SUB   11'h410
`define SLLP_SEC_LAST      10'h3ff
`define SLLP_SEC_MSB       25
`define SLLP_SEC_LSB       16
`define SLLP_SUB_MSB       15
`define SLLP_SUB_LSB       12

// ****************************************
// temporary lock register fields and persistent bit values
// ****************************************
`define SLLP_TL_WRITE_LOCK 0
`define SLLP_TL_LOCK_DOWN  1
`define SLLP_TL_RESET      2'h0
`define SLLP_NV_UNLOCKED   1'h1
`define SLLP_NV_LOCKED     1'h0

// ****************************************
// command codes and frame layout
// ****************************************
`define SLLP_OP_TEMP_WRITE 8'ha1
`define SLLP_OP_TEMP_READ  8'ha2
`define SLLP_OP_NV_PROG    8'ha3
`define SLLP_OP_NV_CLEAR   8'ha4
`define SLLP_OP_NV_READ    8'ha5
`define SLLP_CNT_OPCODE    3'h1
`define SLLP_CNT_ADDR_END  3'h5
`define SLLP_CNT_DATA      3'h6
`define SLLP_CNT_MAX       3'h7

// ****************************************
// timing
// ****************************************
`define SLLP_CLK_NS        20
`define SLLP_BYTE_PROG_NS  100000
`define SLLP_SECT_ERASE_NS 10000000

`endif

// file: verilog/sllp_link.v
// sllp_link.v: serial command link, sampled on the block clock
`timescale 1ns/100ps
module sllp_link (
	input  wire       clock,      // block clock
	input  wire       resetn,     // async reset, active low
	input  wire       sclk,       // link clock pin
	input  wire       cs_n,       // chip select pin, active low
	input  wire       mosi,       // serial data in pin
	input  wire [7:0] tx_byte,    // byte to shift out next
	input  wire       tx_load,    // load tx_byte into the shifter
	input  wire       tx_en,      // drive serial data out
	output reg        byte_valid, // pulse: a whole byte arrived
	output reg  [7:0] byte_data,  // received byte
	output reg        frame_start,// pulse: select went active
	output reg        frame_end,  // pulse: select went idle
	output reg        miso,       // serial data out
	output wire       miso_oe     // output enable of serial data out
);
	// ****************************************
	// three-stage sampling, accept when stages two and three agree
	// ****************************************
	reg [2:0] sclk_s;
	reg [2:0] cs_s;
	reg [2:0] mosi_s;
	reg       sclk_f;
	reg       sclk_d;
	reg       cs_f;
	reg       cs_d;
	reg       mosi_f;
	reg [2:0] bit_cnt;
	reg [7:0] rx_shift;
	reg [7:0] tx_shift;
	wire      rise;
	wire      fall;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclk_s <= 3'h0;
			cs_s   <= 3'h7;
			mosi_s <= 3'h0;
			sclk_f <= 1'h0;
			sclk_d <= 1'h0;
			cs_f   <= 1'h1;
			cs_d   <= 1'h1;
			mosi_f <= 1'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			cs_s   <= {cs_s[1:0], cs_n};
			mosi_s <= {mosi_s[1:0], mosi};
			if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
			if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
			if (mosi_s[1] == mosi_s[2]) mosi_f <= mosi_s[2];
			sclk_d <= sclk_f;
			cs_d   <= cs_f;
		end
	end

	assign rise    = sclk_f & ~sclk_d & ~cs_f;
	assign fall    = ~sclk_f & sclk_d & ~cs_f;
	assign miso_oe = tx_en & ~cs_f;

	// ****************************************
	// shifters: in on rising link edges, out on falling ones
	// ****************************************
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt     <= 3'h0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			byte_valid  <= 1'h0;
			byte_data   <= 8'h00;
			frame_start <= 1'h0;
			frame_end   <= 1'h0;
			miso        <= 1'h0;
		end else begin
			byte_valid  <= 1'h0;
			frame_start <= ~cs_f & cs_d;
			frame_end   <= cs_f & ~cs_d;
			if (cs_f) begin
				bit_cnt <= 3'h0;
			end else if (rise) begin
				rx_shift <= {rx_shift[6:0], mosi_f};
				bit_cnt  <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					byte_valid <= 1'h1;
					byte_data  <= {rx_shift[6:0], mosi_f};
				end
			end
			if (tx_load) begin
				tx_shift <= tx_byte;
			end else if (fall) begin
				miso     <= tx_shift[7];
				tx_shift <= {tx_shift[6:0], 1'h0};
			end
		end
	end
endmodule

// file: verilog/sllp_timer.v
// sllp_timer.v: busy timer for persistent lock operations
`timescale 1ns/100ps
module sllp_timer (
	input  wire        clock,  // block clock
	input  wire        resetn, // async reset, active low
	input  wire        start,  // pulse: begin a timed operation
	input  wire [31:0] count,  // length of the operation in cycles, at least 1
	output reg         busy,   // operation in progress
	output reg         done    // pulse: operation finished
);
	reg [31:0] remain;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			remain <= 32'h0;
			busy   <= 1'h0;
			done   <= 1'h0;
		end else begin
			done <= 1'h0;
			if (start && !busy) begin
				remain <= count;
				busy   <= 1'h1;
			end else if (busy) begin
				if (remain <= 32'h1) begin
					busy <= 1'h0;
					done <= 1'h1;
				end else begin
					remain <= remain - 32'h1;
				end
			end
		end
	end
endmodule

// file: verilog/sllp_top.v
// sllp_top.v: per-sector persistent and temporary write protection
//
// Behaviour
// - persistent bit 0 blocks program and erase
// - persistent bit 1 unlocked; survives resets
// - temporary bit 1 blocks program and erase
// - persistent program clears one bit, byte time
// - persistent clear sets all bits, erase time
// - read commands return persistent or temporary bits
// - every reset clears all temporary bits
// - 8-bit temporary register, bits 7:2 zero
// - temporary write only while lock-down is 0
// - lock-down freezes both bits until reset
// - lock-down bit is 0 after power-up
// - write-lock bit 0 is 0 after power-up
// - temporary bit is the write-lock field
// - whole temporary register readable
// - first/last sectors locked per 4KB subsector
// - freeze 0 refuses persistent program and clear
`timescale 1ns/100ps
`include "sllp_defs.vh"
module sllp_top #(
	parameter BYTE_PROG_NS  = `SLLP_BYTE_PROG_NS,  // persistent bit program time
	parameter SECT_ERASE_NS = `SLLP_SECT_ERASE_NS  // persistent bit clear time
) (
	input  wire        clock,         // block clock, 50 MHz
	input  wire        resetn,        // hardware reset, async, active low
	input  wire        por_n,         // first power-up of the persistent store, active low
	input  wire        soft_reset,    // pulse: software reset
	input  wire        global_freeze, // freeze bit, 0 guards the persistent bits
	input  wire        sclk,          // link clock pin
	input  wire        cs_n,          // chip select pin, active low
	input  wire        mosi,          // serial data in pin
	output wire        miso,          // serial data out pin
	output wire        miso_oe,       // enable of serial data out
	input  wire        pe_req,        // pulse: program or erase wants to start
	input  wire        pe_erase,      // with pe_req: operation is a sector erase
	input  wire [31:0] pe_addr,       // with pe_req: target address
	output reg         pe_done,       // pulse: pe_allowed is valid
	output reg         pe_allowed,    // target is unprotected
	output wire        busy           // persistent lock operation running
);
	// ****************************************
	// derived cycle counts
	// ****************************************
	localparam [31:0] PROG_CYCLES  = (BYTE_PROG_NS + `SLLP_CLK_NS - 1) / `SLLP_CLK_NS;
	localparam [31:0] ERASE_CYCLES = (SECT_ERASE_NS + `SLLP_CLK_NS - 1) / `SLLP_CLK_NS;

	// ****************************************
	// storage
	// ****************************************
	reg        nv_bit [0:`SLLP_SECTORS-1];
	reg [1:0]  tl_reg [0:`SLLP_TL_ENTRIES-1];
	reg [7:0]  opcode;
	reg [31:0] addr;
	reg [2:0]  byte_cnt;
	reg        tx_load;
	reg        tx_en;
	reg        op_clear;
	reg [9:0]  op_sector;
	reg        timer_start;
	reg [31:0] timer_count;
	reg        any_sub;
	reg [7:0]  tx_byte;
	reg [1:0]  tl_cur;
	wire       byte_valid;
	wire [7:0] byte_data;
	wire       frame_start;
	wire       frame_end;
	wire       timer_done;
	wire [9:0] cmd_sector;
	wire [10:0] cmd_idx;
	wire [9:0] pe_sector;
	wire       pe_edge_sector;
	integer    i;
	wire       start_ok;
	wire       prog_frame;
	wire       clear_frame;
	wire       opcode_byte;
	wire       addr_byte;
	wire       data_byte;
	wire       tl_wr;
	wire       pe_nv_locked;
	wire [10:0] pe_idx;
	reg        next_allowed;

	// the persistent store is plain flops loaded by por_n; a real array would
	// keep its bits through power loss on its own, so por_n must be asserted
	// only once, at the first power-up, never with a hardware reset.
	// the gate answers from the lock state seen at pe_req; a lock that lands
	// one cycle later does not withdraw an answer already given.

	// temporary entry of an address; the edge sectors keep one per 4KB subsector
	function [10:0] tl_index;
		input [31:0] a;
		begin
			if (a[`SLLP_SEC_MSB:`SLLP_SEC_LSB] == 10'h000)
				tl_index = `SLLP_TL_FIRST_SUB + {7'h00, a[`SLLP_SUB_MSB:`SLLP_SUB_LSB]};
			else if (a[`SLLP_SEC_MSB:`SLLP_SEC_LSB] == `SLLP_SEC_LAST)
				tl_index = `SLLP_TL_LAST_SUB + {7'h00, a[`SLLP_SUB_MSB:`SLLP_SUB_LSB]};
			else
				tl_index = {1'h0, a[`SLLP_SEC_MSB:`SLLP_SEC_LSB]};
		end
	endfunction

	// sector number of a byte address
	function [9:0] sector_of;
		input [31:0] a;
		begin
			sector_of = a[`SLLP_SEC_MSB:`SLLP_SEC_LSB];
		end
	endfunction

	// opcodes that answer with a data byte
	function is_read_op;
		input [7:0] op;
		begin
			is_read_op = (op == `SLLP_OP_TEMP_READ) || (op == `SLLP_OP_NV_READ);
		end
	endfunction

	assign cmd_sector     = sector_of(addr);
	assign cmd_idx        = tl_index(addr);
	assign pe_sector      = sector_of(pe_addr);
	assign pe_idx         = tl_index(pe_addr);
	assign pe_edge_sector = (pe_sector == 10'h000) || (pe_sector == `SLLP_SEC_LAST);
	assign pe_nv_locked   = (nv_bit[pe_sector] == `SLLP_NV_LOCKED);

	// ****************************************
	// frame byte roles and operation requests
	// ****************************************
	assign opcode_byte = byte_valid && (byte_cnt == 3'h0);
	assign addr_byte   = byte_valid && (byte_cnt != 3'h0) && (byte_cnt < `SLLP_CNT_ADDR_END);
	assign data_byte   = byte_valid && (byte_cnt == `SLLP_CNT_ADDR_END);
	assign tl_wr       = data_byte && (opcode == `SLLP_OP_TEMP_WRITE);
	// a frame that closes while busy is dropped, not queued
	assign start_ok    = frame_end && !busy && global_freeze;
	assign prog_frame  = (opcode == `SLLP_OP_NV_PROG) && (byte_cnt >= `SLLP_CNT_ADDR_END);
	assign clear_frame = (opcode == `SLLP_OP_NV_CLEAR) && (byte_cnt >= `SLLP_CNT_OPCODE);

	// ****************************************
	// link and timer
	// ****************************************
	sllp_link u_link (
		.clock       (clock),
		.resetn      (resetn),
		.sclk        (sclk),
		.cs_n        (cs_n),
		.mosi        (mosi),
		.tx_byte     (tx_byte),
		.tx_load     (tx_load),
		.tx_en       (tx_en),
		.byte_valid  (byte_valid),
		.byte_data   (byte_data),
		.frame_start (frame_start),
		.frame_end   (frame_end),
		.miso        (miso),
		.miso_oe     (miso_oe)
	);

	sllp_timer u_timer (
		.clock  (clock),
		.resetn (resetn),
		.start  (timer_start),
		.count  (timer_count),
		.busy   (busy),
		.done   (timer_done)
	);

	// ****************************************
	// read data
	// ****************************************
	always @* begin
		tl_cur = tl_reg[cmd_idx];
		if (opcode == `SLLP_OP_TEMP_READ)
			tx_byte = {6'h00, tl_cur};
		else if (opcode == `SLLP_OP_NV_READ)
			tx_byte = {8{nv_bit[cmd_sector]}};
		else
			tx_byte = 8'h00;
	end

	// ****************************************
	// command frame decode
	// ****************************************
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			opcode      <= 8'h00;
			addr        <= 32'h0;
			byte_cnt    <= 3'h0;
			tx_load     <= 1'h0;
			tx_en       <= 1'h0;
			timer_start <= 1'h0;
			timer_count <= 32'h1;
			op_clear    <= 1'h0;
			op_sector   <= 10'h000;
		end else begin
			timer_start <= 1'h0;
			tx_load     <= byte_valid;
			if (frame_start) begin
				byte_cnt <= 3'h0;
				tx_en    <= 1'h0;
			end else if (byte_valid) begin
				if (byte_cnt != `SLLP_CNT_MAX)
					byte_cnt <= byte_cnt + 3'h1;
				if (opcode_byte)
					opcode <= byte_data;
				else if (addr_byte)
					addr <= {addr[23:0], byte_data};
				if (byte_cnt == `SLLP_CNT_ADDR_END - 3'h1)
					tx_en <= is_read_op(opcode);
			end
			// persistent operations start when the frame closes, and never while busy
			if (start_ok) begin
				if (prog_frame) begin
					timer_start <= 1'h1;
					timer_count <= PROG_CYCLES;
					op_clear    <= 1'h0;
					op_sector   <= cmd_sector;
				end else if (clear_frame) begin
					timer_start <= 1'h1;
					timer_count <= ERASE_CYCLES;
					op_clear    <= 1'h1;
				end
			end
			if (frame_end)
				tx_en <= 1'h0;
		end
	end

	// ****************************************
	// persistent lock bits: only the first power-up loads them
	// ****************************************
	always @(posedge clock or negedge por_n) begin
		if (!por_n) begin
			for (i = 0; i < `SLLP_SECTORS; i = i + 1)
				nv_bit[i] <= `SLLP_NV_UNLOCKED;
		end else if (timer_done) begin
			if (op_clear) begin
				for (i = 0; i < `SLLP_SECTORS; i = i + 1)
					nv_bit[i] <= `SLLP_NV_UNLOCKED;
			end else begin
				nv_bit[op_sector] <= `SLLP_NV_LOCKED;
			end
		end
	end

	// ****************************************
	// temporary lock registers
	// ****************************************
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < `SLLP_TL_ENTRIES; i = i + 1)
				tl_reg[i] <= `SLLP_TL_RESET;
		end else if (soft_reset) begin
			for (i = 0; i < `SLLP_TL_ENTRIES; i = i + 1)
				tl_reg[i] <= `SLLP_TL_RESET;
		end else if (tl_wr) begin
			// reserved data bits are dropped; lock-down blocks the whole write
			if (!tl_reg[cmd_idx][`SLLP_TL_LOCK_DOWN])
				tl_reg[cmd_idx] <= byte_data[1:0];
		end
	end

	// ****************************************
	// program and erase gate
	// ****************************************
	wire [`SLLP_SUBS-1:0] first_wl;
	wire [`SLLP_SUBS-1:0] last_wl;
	genvar g;
	generate
		for (g = 0; g < `SLLP_SUBS; g = g + 1) begin : g_sub
			assign first_wl[g] = tl_reg[`SLLP_TL_FIRST_SUB + g][`SLLP_TL_WRITE_LOCK];
			assign last_wl[g]  = tl_reg[`SLLP_TL_LAST_SUB + g][`SLLP_TL_WRITE_LOCK];
		end
	endgenerate

	always @* begin
		any_sub = (pe_sector == 10'h000) ? (|first_wl) : (|last_wl);
	end

	always @* begin
		if (pe_nv_locked)
			next_allowed = 1'h0;
		else if (pe_erase && pe_edge_sector)
			// a whole-sector erase on an edge sector needs every subsector free
			next_allowed = ~any_sub;
		else
			next_allowed = ~tl_reg[pe_idx][`SLLP_TL_WRITE_LOCK];
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pe_done    <= 1'h0;
			pe_allowed <= 1'h0;
		end else begin
			pe_done <= pe_req;
			if (pe_req)
				pe_allowed <= next_allowed;
		end
	end
endmodule

// file: verif/sllp_top_properties.sv
// sllp_top_properties.sv: port-level assertions for the sector lock block
`timescale 1ns/100ps
`include "sllp_defs.vh"
module sllp_checker #(
	parameter BYTE_PROG_NS  = 200, // program busy time
	parameter SECT_ERASE_NS = 400  // clear busy time
) (
	input wire        clock,         // block clock
	input wire        resetn,        // reset, active low
	input wire        por_n,         // power-up load
	input wire        soft_reset,    // software reset
	input wire        global_freeze, // freeze bit
	input wire        sclk,          // link clock
	input wire        cs_n,          // link select
	input wire        mosi,          // link data in
	input wire        miso,          // link data out
	input wire        miso_oe,       // link data enable
	input wire        pe_req,        // gate request
	input wire        pe_erase,      // gate erase flag
	input wire [31:0] pe_addr,       // gate address
	input wire        pe_done,       // gate answer
	input wire        pe_allowed,    // gate verdict
	input wire        busy           // persistent op running
);
	// ****************************************
	// busy length counter
	// ****************************************
	localparam int PROG_CYC  = BYTE_PROG_NS / `SLLP_CLK_NS;
	localparam int ERASE_CYC = SECT_ERASE_NS / `SLLP_CLK_NS;
	logic [31:0] blen;
	always @(posedge clock or negedge resetn) begin
		if (!resetn) blen <= 32'h0;
		else if (busy) blen <= blen + 32'h1;
		else blen <= 32'h0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	done_after_req_a: assert property (pe_req |=> pe_done)
		else $error("gate answer missing");
	done_cause_a: assert property (pe_done |-> $past(pe_req))
		else $error("gate answer without request");
	allowed_hold_a: assert property ($changed(pe_allowed) |-> pe_done)
		else $error("verdict moved without answer");
	frozen_refuse_a: assert property (($rose(cs_n) && !global_freeze && !busy) |=> !busy[*8])
		else $error("persistent op started while frozen");
	start_freeze_a: assert property ($rose(busy) |-> global_freeze)
		else $error("busy rose with freeze active");
	busy_min_a: assert property ($rose(busy) |=> busy[*8])
		else $error("busy dropped early");
	busy_len_a: assert property ($fell(busy) |-> (blen == PROG_CYC || blen == ERASE_CYC))
		else $error("busy length wrong");
	oe_idle_a: assert property (cs_n[*8] |-> !miso_oe)
		else $error("data out driven while deselected");
	deny_c: cover property (pe_done && !pe_allowed);
	busy_c: cover property ($fell(busy));
	read_c: cover property (miso_oe && !cs_n);
endmodule

bind sllp_top sllp_checker #(.BYTE_PROG_NS(BYTE_PROG_NS), .SECT_ERASE_NS(SECT_ERASE_NS)) u_chk (
	.clock(clock), .resetn(resetn), .por_n(por_n), .soft_reset(soft_reset),
	.global_freeze(global_freeze), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
	.miso_oe(miso_oe), .pe_req(pe_req), .pe_erase(pe_erase), .pe_addr(pe_addr),
	.pe_done(pe_done), .pe_allowed(pe_allowed), .busy(busy)
);

// file: verif/sllp_host.sv
// sllp_host.sv: serial host model issuing lock commands
`timescale 1ns/100ps
module sllp_host (
	output logic sclk,   // link clock, still low between frames
	output logic cs_n,   // select, active low
	output logic mosi,   // data to the block
	input  wire  miso,   // data from the block
	input  wire  miso_oe // block drives miso
);
	// ****************************************
	// frame engine
	// ****************************************
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// miso taken late in the high phase: the block answers through a synchroniser
	task automatic xfer(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d,
			input int nb, output logic [7:0] rd);
		logic [47:0] sh;
		sh = {op, a, d};
		rd = 8'h00;
		#3 cs_n = 1'b0;
		#80;
		for (int i = 0; i < nb * 8; i++) begin
			mosi = sh[47 - i];
			#80 sclk = 1'b1;
			#80 rd = {rd[6:0], miso_oe ? miso : 1'bx};
			sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		mosi = ~mosi; // no stale bit after release
		#160;
	endtask
endmodule

// file: verif/sllp_top_tb_top.sv
// sllp_top_tb_top.sv: directed bench for the sector lock block
`timescale 1ns/100ps
`include "sllp_defs.vh"
module sllp_top_tb_top;
	localparam int PROG_NS   = 200;
	localparam int ERASE_NS  = 400;
	localparam int PROG_CYC  = PROG_NS / `SLLP_CLK_NS;
	localparam int ERASE_CYC = ERASE_NS / `SLLP_CLK_NS;
	logic        clock, resetn, por_n, soft_reset, global_freeze, pe_req, pe_erase;
	logic [31:0] pe_addr;
	logic [7:0]  rd;
	wire         sclk, cs_n, mosi, miso, miso_oe, pe_done, pe_allowed, busy;
	int          errors, n_compared, busy_cnt;

	// ****************************************
	// clock, design, host
	// ****************************************
	always #10 clock = ~clock;
	always @(negedge clock) if (busy === 1'b1) busy_cnt++;
	sllp_top #(.BYTE_PROG_NS(PROG_NS), .SECT_ERASE_NS(ERASE_NS)) dut (
		.clock(clock), .resetn(resetn), .por_n(por_n), .soft_reset(soft_reset),
		.global_freeze(global_freeze), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .pe_req(pe_req), .pe_erase(pe_erase),
		.pe_addr(pe_addr), .pe_done(pe_done), .pe_allowed(pe_allowed), .busy(busy)
	);
	sllp_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

	// ****************************************
	// access tasks
	// ****************************************
	function automatic logic [31:0] sa(input int s);
		return 32'(s << 16);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic gate(input logic [31:0] a, input logic e, input logic exp);
		@(negedge clock);
		pe_req = 1'b1;
		pe_erase = e;
		pe_addr = a;
		@(negedge clock);
		pe_req = 1'b0;
		chk({6'h0, pe_done, pe_allowed}, {6'h0, 1'b1, exp}, "gate answer");
	endtask
	task automatic rd_chk(input logic [7:0] op, input logic [31:0] a, input logic [7:0] exp);
		host.xfer(op, a, 8'h00, 6, rd);
		chk(rd, exp, "lock read");
	endtask
	task automatic wr_temp(input logic [31:0] a, input logic [7:0] d);
		host.xfer(`SLLP_OP_TEMP_WRITE, a, d, 6, rd);
	endtask
	// a refused op waits out the whole bound, a started one ends at busy fall
	task automatic nv_op(input logic [7:0] op, input int nb, input int exp);
		int k;
		busy_cnt = 0;
		host.xfer(op, sa(9), 8'h00, nb, rd);
		for (k = 0; k < 100; k++) begin
			@(negedge clock);
			if (busy_cnt > 0 && busy === 1'b0) break;
		end
		if (exp > 0 && k == 100) begin
			errors++;
			$display("CHECK FAILED at %0t: persistent op timed out", $time);
			give_verdict();
		end else begin
			chk(8'(busy_cnt), 8'(exp), "persistent busy length");
		end
	endtask
	task automatic hw_reset();
		@(negedge clock);
		resetn = 1'b0;
		@(negedge clock);
		resetn = 1'b1;
		repeat (6) @(negedge clock);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		por_n = 1'b0;
		soft_reset = 1'b0;
		global_freeze = 1'b1;
		pe_req = 1'b0;
		pe_erase = 1'b0;
		pe_addr = 32'h0;
		errors = 0;
		n_compared = 0;
		busy_cnt = 0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		por_n = 1'b1;
		repeat (6) @(negedge clock);
		gate(sa(5), 1'b0, 1'b1);
		rd_chk(`SLLP_OP_TEMP_READ, sa(5), 8'h00);
		rd_chk(`SLLP_OP_NV_READ, sa(5), 8'hff);
		$display("test power_up done");
		wr_temp(sa(5), 8'h01);
		rd_chk(`SLLP_OP_TEMP_READ, sa(5), 8'h01);
		gate(sa(5), 1'b0, 1'b0);
		gate(sa(6), 1'b1, 1'b1);
		wr_temp(sa(5), 8'h00);
		rd_chk(`SLLP_OP_TEMP_READ, sa(5), 8'h00);
		wr_temp(sa(8), 8'hfd);
		rd_chk(`SLLP_OP_TEMP_READ, sa(8), 8'h01);
		$display("test write_lock done");
		wr_temp(sa(7), 8'h03);
		wr_temp(sa(7), 8'h00);
		rd_chk(`SLLP_OP_TEMP_READ, sa(7), 8'h03);
		gate(sa(7), 1'b1, 1'b0);
		@(negedge clock);
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		rd_chk(`SLLP_OP_TEMP_READ, sa(8), 8'h00);
		wr_temp(sa(7), 8'h01);
		rd_chk(`SLLP_OP_TEMP_READ, sa(7), 8'h01);
		$display("test lock_down done");
		wr_temp(32'h0000_3000, 8'h01);
		gate(32'h0000_3000, 1'b0, 1'b0);
		gate(32'h0000_4000, 1'b0, 1'b1);
		gate(32'h0000_0000, 1'b1, 1'b0);
		wr_temp(32'h03ff_f000, 8'h01);
		gate(32'h03ff_f000, 1'b0, 1'b0);
		gate(32'h03ff_0000, 1'b0, 1'b1);
		hw_reset();
		gate(32'h0000_3000, 1'b0, 1'b1);
		rd_chk(`SLLP_OP_TEMP_READ, sa(7), 8'h00);
		$display("test subsector done");
		@(negedge clock);
		global_freeze = 1'b0;
		nv_op(`SLLP_OP_NV_PROG, 5, 0);
		rd_chk(`SLLP_OP_NV_READ, sa(9), 8'hff);
		global_freeze = 1'b1;
		nv_op(`SLLP_OP_NV_PROG, 5, PROG_CYC);
		rd_chk(`SLLP_OP_NV_READ, sa(9), 8'h00);
		gate(sa(9), 1'b0, 1'b0);
		gate(sa(10), 1'b0, 1'b1);
		hw_reset();
		rd_chk(`SLLP_OP_NV_READ, sa(9), 8'h00);
		global_freeze = 1'b0;
		nv_op(`SLLP_OP_NV_CLEAR, 1, 0);
		global_freeze = 1'b1;
		nv_op(`SLLP_OP_NV_CLEAR, 1, ERASE_CYC);
		rd_chk(`SLLP_OP_NV_READ, sa(9), 8'hff);
		gate(sa(9), 1'b1, 1'b1);
		$display("test persistent done");
		give_verdict();
	end
endmodule
